// ### rtl/afect_regs.sv
// Serial register slave, output drive, soft reset and round-robin conversion trigger
`timescale 1ns/10ps
module afect_regs
    import afect_pkg::*;
(
    input  wire logic        i_clk,          // System clock, 10 MHz
    input  wire logic        i_rst,          // Async reset, active high
    input  wire logic        i_sclk,         // Serial link clock
    input  wire logic        i_csb_n,        // Frame select, active low
    input  wire logic        i_sdi,          // Serial data in
    output logic             o_sdo,          // Serial data out value
    output logic             o_sdo_oe_n,     // Serial data out enable, low drives
    input  wire logic        i_conv_mode,    // Power mode is conversion
    input  wire logic        i_lock,         // Lock bit from the register bank
    input  wire logic        i_continuous,   // Continuous round robin selected
    input  wire logic [2:0]  i_chan_en,      // Channel enables
    output logic             o_conv_req,     // Start conversion pulse
    output logic [1:0]       o_conv_chan,    // Channel being converted
    input  wire logic        i_conv_done,    // Conversion finished pulse
    input  wire logic [15:0] i_conv_data,    // Raw conversion result
    input  wire logic        i_amp_ovr,      // Amplifier over-range with result
    input  wire logic        i_dgain_ovr,    // Digital gain over-range with result
    input  wire logic        i_brownout,     // Brown-out with result
    output logic             o_result_valid, // Result strobe
    output logic [1:0]       o_result_chan,  // Result channel
    output logic [15:0]      o_result_data,  // Result after masking
    output logic             o_soft_rst      // Soft reset level, clock domain
);

    // Link domain
    logic [4:0]  bit_cnt_ff;
    logic [14:0] shift_ff;
    logic        rd_ff;
    logic [7:0]  rdbuf_ff;
    logic        rd_phase_ff;
    logic        sdo_ff;
    logic [7:0]  alarm_ff;
    logic        drive_mode_ff;
    logic        st_idle_ff;
    logic        soft_rst_ff;
    logic        start_tgl_ff;
    logic [1:0]  idle_sync_ff;
    logic [6:0]  hdr_addr;
    logic        wr_en;
    logic [6:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        wr_reset_one;

    // Header decode on the eighth rising edge, write decode on the sixteenth
    assign hdr_addr     = {shift_ff[5:0], i_sdi};
    assign wr_en        = (bit_cnt_ff == FRAME_LAST_CNT) && !shift_ff[14];
    assign wr_addr      = shift_ff[13:7];
    assign wr_data      = {shift_ff[6:0], i_sdi};
    assign wr_reset_one = wr_en && (wr_addr == ADDR_SOFT_RST) && wr_data[SOFT_RST_BIT];

    // Frame position; the link clock stops between frames so the select ends it
    always_ff @(posedge i_sclk or posedge i_csb_n or posedge i_rst)
    begin
        if (i_rst || i_csb_n)
        begin
            bit_cnt_ff <= 5'h00;
            shift_ff   <= 15'h0000;
        end
        else
        begin
            shift_ff <= {shift_ff[13:0], i_sdi};
            if (bit_cnt_ff != FRAME_BITS)
            begin
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
            end
        end
    end

    // Read data snapshot taken once the address is known
    always_ff @(posedge i_sclk or posedge i_csb_n or posedge i_rst)
    begin
        if (i_rst || i_csb_n)
        begin
            rd_ff    <= 1'b0;
            rdbuf_ff <= 8'h00;
        end
        else if (bit_cnt_ff == HDR_LAST_CNT)
        begin
            rd_ff <= shift_ff[6];
            unique case (hdr_addr)
                ADDR_ALARM:      rdbuf_ff <= alarm_ff & ALARM_RW_MASK;
                ADDR_DRIVE_MODE: rdbuf_ff <= {7'h00, drive_mode_ff};
                ADDR_SOFT_RST:   rdbuf_ff <= {7'h00, soft_rst_ff};
                ADDR_STATUS:     rdbuf_ff <= {7'h00, idle_sync_ff[1]};
                default:         rdbuf_ff <= 8'h00;
            endcase
        end
    end

    // Data leaves on falling edges so the host samples on the next rising edge
    always_ff @(negedge i_sclk or posedge i_csb_n or posedge i_rst)
    begin
        if (i_rst || i_csb_n)
        begin
            rd_phase_ff <= 1'b0;
            sdo_ff      <= 1'b1;
        end
        else if (rd_ff && (bit_cnt_ff >= 5'h08) && (bit_cnt_ff <= FRAME_LAST_CNT))
        begin
            rd_phase_ff <= 1'b1;
            sdo_ff      <= rdbuf_ff[3'(FRAME_LAST_CNT - bit_cnt_ff)];
        end
    end

    // Released outside read-back unless the always-driven mode holds it high
    assign o_sdo_oe_n = !(rd_phase_ff || drive_mode_ff);
    assign o_sdo      = rd_phase_ff ? sdo_ff : 1'b1;

    // Configuration writes; soft reset holds everything at default
    always_ff @(posedge i_sclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            alarm_ff      <= ALARM_RST;
            drive_mode_ff <= DRIVE_MODE_RST;
        end
        else if (soft_rst_ff || wr_reset_one)
        begin
            alarm_ff      <= ALARM_RST;
            drive_mode_ff <= DRIVE_MODE_RST;
        end
        else if (wr_en && (wr_addr == ADDR_ALARM))
        begin
            alarm_ff <= wr_data & ALARM_RW_MASK;
        end
        else if (wr_en && (wr_addr == ADDR_DRIVE_MODE))
        begin
            drive_mode_ff <= wr_data[SDO_DRIVE_BIT];
        end
    end

    // The bit stays set until the host writes zero
    always_ff @(posedge i_sclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            soft_rst_ff <= SOFT_RST_RST;
        end
        else if (wr_en && (wr_addr == ADDR_SOFT_RST))
        begin
            soft_rst_ff <= wr_data[SOFT_RST_BIT];
        end
    end

    // Any write to the start location while soft reset is clear is an event, whatever the data
    always_ff @(posedge i_sclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            start_tgl_ff <= 1'b0;
        end
        else if (wr_en && (wr_addr == ADDR_START) && !soft_rst_ff)
        begin
            start_tgl_ff <= !start_tgl_ff;
        end
    end

    // Only updates while the link clock runs, which is enough for the next read
    always_ff @(posedge i_sclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            idle_sync_ff <= 2'h0;
        end
        else
        begin
            idle_sync_ff <= {idle_sync_ff[0], st_idle_ff};
        end
    end

    // System clock domain
    logic [2:0]   start_sync_ff;
    logic [1:0]   srst_sync_ff;
    logic [2:0]   mask_s1_ff;
    logic [2:0]   mask_s2_ff;
    logic         start_evt;
    logic         start_ok;
    afect_state_t st_ff;
    afect_state_t nxt_st;
    logic [1:0]   chan_ff;
    logic [1:0]   nxt_chan;
    logic         force_err;
    logic [1:0]   first_chan;
    logic [1:0]   after_chan;

    // Lowest enabled channel at or above start, NO_CHAN when none
    function automatic logic [1:0] afect_find_chan(input logic [2:0] from_mask, input logic [2:0] en);
        logic [2:0] hit;
        hit = en & from_mask;
        if (hit[0])
            afect_find_chan = 2'h0;
        else if (hit[1])
            afect_find_chan = 2'h1;
        else if (hit[2])
            afect_find_chan = 2'h2;
        else
            afect_find_chan = NO_CHAN;
    endfunction

    // Mask bits are quasi-static; each bit is synchronised on its own
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            start_sync_ff <= 3'h0;
            srst_sync_ff  <= 2'h0;
            mask_s1_ff    <= 3'h0;
            mask_s2_ff    <= 3'h0;
        end
        else
        begin
            start_sync_ff <= {start_sync_ff[1:0], start_tgl_ff};
            srst_sync_ff  <= {srst_sync_ff[0], soft_rst_ff};
            mask_s1_ff    <= {alarm_ff[MASK_BROWN_BIT], alarm_ff[MASK_DGAIN_BIT], alarm_ff[MASK_AMP_BIT]};
            mask_s2_ff    <= mask_s1_ff;
        end
    end

    assign start_evt  = start_sync_ff[2] ^ start_sync_ff[1];
    assign start_ok   = i_lock && i_conv_mode;
    assign first_chan = afect_find_chan(3'h7, i_chan_en);
    assign after_chan = (chan_ff == 2'h2) ? NO_CHAN : afect_find_chan(3'h7 << (chan_ff + 2'h1), i_chan_en);
    assign o_soft_rst = srst_sync_ff[1];

    always_comb
    begin
        nxt_st   = st_ff;
        nxt_chan = chan_ff;
        unique case (st_ff)
            ST_IDLE:
            begin
                if (start_evt && start_ok && (first_chan != NO_CHAN))
                begin
                    nxt_st   = ST_REQ;
                    nxt_chan = first_chan;
                end
            end
            ST_REQ:
            begin
                nxt_st = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (i_conv_done)
                begin
                    nxt_st = ST_NEXT;
                end
            end
            ST_NEXT:
            begin
                if (!i_conv_mode)
                begin
                    nxt_st = ST_IDLE;
                end
                else if (after_chan != NO_CHAN)
                begin
                    nxt_st   = ST_REQ;
                    nxt_chan = after_chan;
                end
                else if (i_continuous && (first_chan != NO_CHAN))
                begin
                    nxt_st   = ST_REQ;
                    nxt_chan = first_chan;
                end
                else
                begin
                    nxt_st = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_ff      <= ST_IDLE;
            chan_ff    <= 2'h0;
            st_idle_ff <= 1'b1;
        end
        else if (srst_sync_ff[1])
        begin
            st_ff      <= ST_IDLE;
            chan_ff    <= 2'h0;
            st_idle_ff <= 1'b1;
        end
        else
        begin
            st_ff      <= nxt_st;
            chan_ff    <= nxt_chan;
            st_idle_ff <= (nxt_st == ST_IDLE);
        end
    end

    assign o_conv_req  = (st_ff == ST_REQ);
    assign o_conv_chan = chan_ff;

    // Unmasked alarms replace the result with the error code
    assign force_err = (i_amp_ovr && !mask_s2_ff[0])
                    || (i_dgain_ovr && !mask_s2_ff[1])
                    || (i_brownout && !mask_s2_ff[2]);

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_result_valid <= 1'b0;
            o_result_chan  <= 2'h0;
            o_result_data  <= 16'h0000;
        end
        else
        begin
            o_result_valid <= (st_ff == ST_WAIT) && i_conv_done && !srst_sync_ff[1];
            if ((st_ff == ST_WAIT) && i_conv_done)
            begin
                o_result_chan <= chan_ff;
                o_result_data <= force_err ? ERR_CODE : i_conv_data;
            end
        end
    end

    // Checks
    a_amp_err_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_ff == ST_WAIT && i_conv_done && i_amp_ovr && !mask_s2_ff[0] && !srst_sync_ff[1])
        |=> (o_result_valid && o_result_data == 16'h7fff))
        else $error("unmasked amplifier over-range did not give error code");
    a_amp_mask_pass: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_ff == ST_WAIT && i_conv_done && i_amp_ovr && mask_s2_ff == 3'h7)
        |=> (o_result_data == $past(i_conv_data)))
        else $error("masked amplifier over-range altered result");
    a_dgain_mask_pass: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_ff == ST_WAIT && i_conv_done && i_dgain_ovr && mask_s2_ff[1] && !i_amp_ovr && !i_brownout)
        |=> (o_result_data == $past(i_conv_data)))
        else $error("masked digital gain over-range altered result");
    a_sdo_hiz_idle: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_csb_n && !drive_mode_ff) |-> o_sdo_oe_n)
        else $error("serial output driven outside read-back");
    a_sdo_drive_high: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_csb_n && drive_mode_ff) |-> (!o_sdo_oe_n && o_sdo))
        else $error("serial output not held high in driven mode");
    a_soft_rst_clear: assert property (@(posedge i_sclk) disable iff (i_rst)
        soft_rst_ff |-> (alarm_ff == 8'h00 && !drive_mode_ff))
        else $error("registers not at default during soft reset");
    a_start_locked: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_ff == ST_IDLE && start_evt && !start_ok) |=> (st_ff == ST_IDLE)[*2])
        else $error("start accepted while lock or mode clear");
    a_start_launch: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_ff == ST_IDLE && start_evt && start_ok && i_chan_en != 3'h0 && !srst_sync_ff[1])
        |=> (o_conv_req && o_conv_chan == $past(first_chan)) ##1 (st_ff == ST_WAIT))
        else $error("start write did not launch conversion");
    a_single_stop: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_ff == ST_NEXT && !i_continuous && after_chan == NO_CHAN && !srst_sync_ff[1])
        |=> (st_ff == ST_IDLE && !o_conv_req))
        else $error("single shot did not stop after last channel");
    a_cont_repeat: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_ff == ST_NEXT && i_continuous && i_conv_mode && i_chan_en != 3'h0 && !srst_sync_ff[1])
        |=> ##[0:1] o_conv_req)
        else $error("continuous mode did not continue");
    a_unused_zero: assert property (@(posedge i_sclk) disable iff (i_rst || i_csb_n)
        (bit_cnt_ff == 5'h07 && hdr_addr == ADDR_ALARM) |=> (rdbuf_ff[5:1] == 5'h00))
        else $error("unused alarm mask bits read non-zero");

endmodule

// ### rtl/afect_pkg.sv
// Package of constants and types for the front-end control and trigger register block
package afect_pkg;

    // Register addresses on the serial link
    localparam logic [6:0]  ADDR_ALARM      = 7'h05;
    localparam logic [6:0]  ADDR_DRIVE_MODE = 7'h06;
    localparam logic [6:0]  ADDR_SOFT_RST   = 7'h07;
    localparam logic [6:0]  ADDR_START      = 7'h0f;
    localparam logic [6:0]  ADDR_STATUS     = 7'h10;

    // Field positions
    localparam int          MASK_AMP_BIT    = 0;
    localparam int          MASK_DGAIN_BIT  = 6;
    localparam int          MASK_BROWN_BIT  = 7;
    localparam int          SDO_DRIVE_BIT   = 0;
    localparam int          SOFT_RST_BIT    = 0;
    localparam int          START_BIT       = 7;
    localparam int          READY_BIT       = 0;

    // Implemented bits and reset values
    localparam logic [7:0]  ALARM_RW_MASK   = 8'hc1;
    localparam logic [7:0]  ALARM_RST       = 8'h00;
    localparam logic        DRIVE_MODE_RST  = 1'h0;
    localparam logic        SOFT_RST_RST    = 1'h0;

    // Result forced on an unmasked over-range or brown-out
    localparam logic [15:0] ERR_CODE        = 16'h7fff;

    // Serial frame layout: read flag, 7 address bits, 8 data bits
    localparam logic [4:0]  HDR_LAST_CNT    = 5'h07;
    localparam logic [4:0]  FRAME_LAST_CNT  = 5'h0f;
    localparam logic [4:0]  FRAME_BITS      = 5'h10;
    localparam logic [1:0]  NUM_CHAN        = 2'h3;
    localparam logic [1:0]  NO_CHAN         = 2'h3;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_REQ  = 2'h1,
        ST_WAIT = 2'h3,
        ST_NEXT = 2'h2
    } afect_state_t;

endpackage

// ### tb/afect_spi_host.sv
// SPI host model that frames register accesses on its own link clock
`timescale 1ns/10ps
module afect_spi_host
(
    output logic      o_sclk,    // Link clock, low and still outside frames
    output logic      o_csb_n,   // Frame select, active low
    output logic      o_sdi,     // Serial data to the device
    input  wire logic i_sdo_pin  // Resolved serial data pin
);
    localparam int HALF = 80;

    initial
    begin
        o_sclk  = 1'b0;
        o_csb_n = 1'b1;
        o_sdi   = 1'b0;
    end

    // One frame: read flag, address, data, MSB first; data changes after falling edges
    task automatic xfer(input logic [15:0] w, output logic [7:0] r);
        r = 8'h00;
        #13;
        o_csb_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            o_sdi = w[i];
            #(HALF);
            o_sclk = 1'b1;
            if (i < 8)
                r = {r[6:0], i_sdo_pin};
            #(HALF);
            o_sclk = 1'b0;
        end
        #(HALF);
        o_csb_n = 1'b1;
        // Serial data to the device is inverted after the frame; the device ignores it while the select is high
        o_sdi = ~o_sdi;
        // Gap long enough for the clock domain to see each frame apart
        #400;
    endtask
endmodule

// ### tb/afect_regs_tb_top.sv
// Self-checking testbench for the control and trigger register block
`timescale 1ns/10ps
module afect_regs_tb_top;
    import afect_pkg::*;
    logic        i_clk, i_rst, sclk, csb_n, sdi, sdo, sdo_oe_n, soft_rst;
    logic        conv_mode, lock, cont, conv_req, conv_done, amp, dg, br, res_valid;
    logic [2:0]  chan_en;
    logic [1:0]  conv_chan, res_chan, exp_chan, ch;
    logic [15:0] conv_data, res_data;
    logic [7:0]  mask_v, rd;
    logic [31:0] seed = 32'h4c80;
    logic [17:0] exp_q[$];
    int          fails, checked, req_cnt, cyc, base;
    wire         sdo_pin = sdo_oe_n ? 1'bz : sdo;

    afect_regs uut (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_csb_n(csb_n), .i_sdi(sdi), .o_sdo(sdo),
        .o_sdo_oe_n(sdo_oe_n), .i_conv_mode(conv_mode), .i_lock(lock), .i_continuous(cont),
        .i_chan_en(chan_en), .o_conv_req(conv_req), .o_conv_chan(conv_chan), .i_conv_done(conv_done),
        .i_conv_data(conv_data), .i_amp_ovr(amp), .i_dgain_ovr(dg), .i_brownout(br),
        .o_result_valid(res_valid), .o_result_chan(res_chan), .o_result_data(res_data), .o_soft_rst(soft_rst));
    afect_spi_host host (.o_sclk(sclk), .o_csb_n(csb_n), .o_sdi(sdi), .i_sdo_pin(sdo_pin));

    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Next enabled channel above c, wrapping to the lowest
    function automatic logic [1:0] next_en(input logic [1:0] c);
        logic [1:0] n;
        n = c;
        for (int k = 0; k < 3; k++)
        begin
            n = (n == 2'h2) ? 2'h0 : n + 2'h1;
            if (chan_en[n])
                return n;
        end
        return c;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic spi_wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        host.xfer({1'b0, a, d}, r);
    endtask

    task automatic spi_rd(input logic [6:0] a, output logic [7:0] d);
        host.xfer({1'b1, a, 8'h00}, d);
    endtask

    // Waits for n requests and an empty result queue, then a quiet spell
    task automatic wait_reqs(input int n);
        int k;
        k = 0;
        while ((req_cnt < n || exp_q.size() != 0) && k < 500)
        begin
            @(negedge i_clk);
            k++;
        end
        repeat (40) @(negedge i_clk);
    endtask

    // Register write is the only trigger available here; no sync pin on this block
    task automatic shot(input logic [7:0] m, input logic [2:0] en);
        spi_wr(ADDR_ALARM, m);
        @(negedge i_clk);
        mask_v = m & ALARM_RW_MASK;
        chan_en = en;
        lock = 1'b1;
        exp_chan = next_en(2'h2);
        base = req_cnt;
        spi_wr(ADDR_START, 8'h80);
        wait_reqs(base + $countones(en));
        check(req_cnt, base + $countones(en));
        spi_rd(ADDR_STATUS, rd);
        check(rd, 8'h01);
        @(negedge i_clk);
        lock = 1'b0;
    endtask

    // Converter stand-in: answers each request after a few cycles with random data and flags
    initial
    begin
        forever
        begin
            @(negedge i_clk);
            if (conv_req === 1'b1)
            begin
                check(32'(conv_chan), 32'(exp_chan));
                ch = exp_chan;
                exp_chan = next_en(exp_chan);
                req_cnt++;
                repeat (3) @(negedge i_clk);
                seed = xs(seed);
                conv_data = seed[15:0];
                amp = seed[16];
                dg = seed[17];
                br = seed[18];
                if ((amp & ~mask_v[0]) | (dg & ~mask_v[6]) | (br & ~mask_v[7]))
                    exp_q.push_back({ch, ERR_CODE});
                else
                    exp_q.push_back({ch, seed[15:0]});
                conv_done = 1'b1;
                @(negedge i_clk);
                conv_done = 1'b0;
            end
        end
    end

    initial
    begin
        forever
        begin
            @(negedge i_clk);
            if (res_valid === 1'b1)
            begin
                if (exp_q.size() == 0)
                    check(32'h1, 32'h0);
                else
                    check(32'({res_chan, res_data}), 32'(exp_q.pop_front()));
            end
        end
    end

    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fails++;
            tally_and_finish();
        end
    end

    initial
    begin
        i_rst = 1'b1;
        {conv_mode, lock, cont, conv_done, amp, dg, br} = 7'h00;
        chan_en = 3'h0;
        conv_data = 16'h0000;
        mask_v = 8'h00;
        exp_chan = 2'h0;
        repeat (6) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (2) @(negedge i_clk);
        check(sdo_oe_n, 1'b1);
        spi_rd(ADDR_ALARM, rd);
        check(rd, 8'h00);
        spi_rd(ADDR_DRIVE_MODE, rd);
        check(rd, 8'h00);
        spi_wr(ADDR_ALARM, 8'hff);
        spi_rd(ADDR_ALARM, rd);
        check(rd, 8'hc1);
        spi_wr(ADDR_DRIVE_MODE, 8'hff);
        spi_rd(ADDR_DRIVE_MODE, rd);
        check(rd, 8'h01);
        @(negedge i_clk);
        check({sdo_oe_n, sdo}, 2'b01);
        spi_rd(ADDR_START, rd);
        check(rd, 8'h00);
        spi_rd(7'h30, rd);
        check(rd, 8'h00);
        spi_wr(ADDR_SOFT_RST, 8'hff);
        check(soft_rst, 1'b1);
        spi_rd(ADDR_SOFT_RST, rd);
        check(rd, 8'h01);
        spi_rd(ADDR_ALARM, rd);
        check(rd, 8'h00);
        spi_rd(ADDR_DRIVE_MODE, rd);
        check(rd, 8'h00);
        spi_wr(ADDR_SOFT_RST, 8'h00);
        @(negedge i_clk);
        check(soft_rst, 1'b0);
        check(sdo_oe_n, 1'b1);
        conv_mode = 1'b1;
        chan_en = 3'h7;
        spi_wr(ADDR_START, 8'h80);
        wait_reqs(0);
        check(req_cnt, 0);
        conv_mode = 1'b0;
        lock = 1'b1;
        spi_wr(ADDR_START, 8'h80);
        wait_reqs(0);
        check(req_cnt, 0);
        conv_mode = 1'b1;
        lock = 1'b0;
        shot(8'h00, 3'b101);
        shot(8'h01, 3'b010);
        shot(8'h40, 3'b111);
        shot(8'hc1, 3'b100);
        shot(8'h80, 3'b011);
        spi_wr(ADDR_ALARM, 8'hc1);
        mask_v = 8'hc1;
        cont = 1'b1;
        lock = 1'b1;
        chan_en = 3'b110;
        exp_chan = next_en(2'h2);
        base = req_cnt;
        spi_wr(ADDR_START, 8'h80);
        for (int k = 0; k < 500 && req_cnt < base + 8; k++)
            @(negedge i_clk);
        check(req_cnt >= base + 8, 1'b1);
        conv_mode = 1'b0;
        wait_reqs(0);
        base = req_cnt;
        wait_reqs(0);
        check(req_cnt, base);
        tally_and_finish();
    end
endmodule
